// ===== logic/vdc_consts.svh
// timing constants and register map for the video dram controller
`ifndef VDC_CONSTS_SVH
`define VDC_CONSTS_SVH

// clock period in picoseconds (250 MHz)
`define VDC_CLK_PS        4000
// power-up pause, microseconds
`define VDC_T_PWRUP_US    200
`define VDC_PWRUP_CYC     ((`VDC_T_PWRUP_US * 1000000 + `VDC_CLK_PS - 1) / `VDC_CLK_PS)
// init strobe cycles
`define VDC_INIT_CYCLES   8
// minimum times in nanoseconds (slowest grade)
`define VDC_T_RP_NS       60
`define VDC_T_RAS_NS      80
`define VDC_T_CAS_NS      20
`define VDC_T_RAH_NS      15
`define VDC_T_CSR_NS      5
`define VDC_T_OEA_NS      20
`define VDC_T_DH_NS       15
`define VDC_NS2CYC(ns)    (((ns) * 1000 + `VDC_CLK_PS - 1) / `VDC_CLK_PS)

// register byte offsets
`define VDC_REG_CTRL      12'h000
`define VDC_REG_ADDR      12'h004
`define VDC_REG_WDATA     12'h008
`define VDC_REG_MASK      12'h00c
`define VDC_REG_RDATA     12'h010
`define VDC_REG_STAT      12'h014

// ctrl fields: [2:0] command, [3] start, [5:4] byte enables
`define VDC_CTRL_START    3
`define VDC_CTRL_BE_LO    4
`define VDC_CTRL_BE_HI    5
// status fields
`define VDC_STAT_BUSY     0
`define VDC_STAT_INIT     1
`define VDC_STAT_OLDMASK  2

`endif

// ===== logic/vdc_pkg.sv
// types for the video dram controller
`default_nettype none
package vdc_pkg;
   typedef enum logic [2:0] {
      VDC_CMD_READ     = 3'h0,
      VDC_CMD_WRITE    = 3'h1,
      VDC_CMD_MWRITE   = 3'h2,
      VDC_CMD_LOADMASK = 3'h3,
      VDC_CMD_REFRESH  = 3'h4,
      VDC_CMD_OPTRST   = 3'h5
   } vdc_cmd_t;

   typedef enum logic [9:0] {
      VDC_ST_PWRUP = 10'h001,
      VDC_ST_INIT  = 10'h002,
      VDC_ST_IDLE  = 10'h004,
      VDC_ST_RAS   = 10'h008,
      VDC_ST_COL   = 10'h010,
      VDC_ST_CAS   = 10'h020,
      VDC_ST_DATA  = 10'h040,
      VDC_ST_HOLD  = 10'h080,
      VDC_ST_PRE   = 10'h100,
      VDC_ST_CBR   = 10'h200
   } vdc_state_t;
endpackage
`default_nettype wire

// ===== logic/vdc_sync.sv
// three-stage synchroniser for the data pins read back from the device
`default_nettype none
module vdc_sync
   #(parameter int W = 16)
   (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
   );
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // output only moves once stages two and three agree
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q    <= '0;
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            q <= s3_q;
      end
   end
endmodule
`default_nettype wire

// ===== logic/vdc_ctrl.sv
// host-side controller driving the random-access port of a video dram
//
// Function
// - wait 200us, eight strobe cycles, transfer pin high
// - init uses eight ras-only cycles; counter refresh only after init
// - read command held past column or row strobe
// - eighteen bits: nine row then nine column
// - row on row-strobe fall, column on column-strobe
// - both strobes high, then row precharge time
// - never abort before minimum strobe widths
// - write enables high throughout means read
// - read data only while output enable low
// - column strobe low before row strobe refreshes
`include "vdc_consts.svh"
`default_nettype none
module vdc_ctrl
   import vdc_pkg::*;
   (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             row_strobe_n,
   output logic             col_strobe_n,
   output logic [8:0]       dram_addr,
   output logic             lower_byte_write_enable_n,
   output logic             upper_byte_write_enable_n,
   output logic             transfer_output_enable_n,
   output logic             special_function_select,
   output logic             serial_shift_clock,
   input  wire logic [15:0] data_mask_pins_i,
   output logic [15:0]      data_mask_pins_o,
   output logic             data_mask_pins_oe_n
   );
   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam int PWRUP = `VDC_PWRUP_CYC;
   localparam logic [15:0] C_RP  = 16'(`VDC_NS2CYC(`VDC_T_RP_NS));
   localparam logic [15:0] C_RAS = 16'(`VDC_NS2CYC(`VDC_T_RAS_NS));
   localparam logic [15:0] C_CAS = 16'(`VDC_NS2CYC(`VDC_T_CAS_NS));
   localparam logic [15:0] C_RAH = 16'(`VDC_NS2CYC(`VDC_T_RAH_NS));
   localparam logic [15:0] C_CSR = 16'(`VDC_NS2CYC(`VDC_T_CSR_NS));
   localparam logic [15:0] C_OEA = 16'(`VDC_NS2CYC(`VDC_T_OEA_NS));
   localparam logic [15:0] C_DH  = 16'(`VDC_NS2CYC(`VDC_T_DH_NS));

   vdc_state_t  st_q;
   logic [17:0] pwr_q;
   logic [15:0] tmr_q;
   logic [3:0]  icnt_q;
   logic [2:0]  cmd_q;
   logic [17:0] addr_q;
   logic [15:0] wdata_q;
   logic [15:0] mask_q;
   logic [15:0] rdata_q;
   logic [1:0]  be_q;
   logic        start_q;
   logic        oldmask_q;
   logic        aw_q;
   logic        w_q;
   logic [11:0] awaddr_q;
   logic [31:0] wd_q;
   logic [15:0] din;
   logic        busy;
   logic        is_wr;

   vdc_sync #(.W(16)) u_sync
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (data_mask_pins_i),
      .q       (din)
   );

   assign busy  = (st_q != VDC_ST_IDLE) || start_q;
   assign is_wr = (cmd_q == VDC_CMD_WRITE) || (cmd_q == VDC_CMD_MWRITE);

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign s_axi_bresp   = 2'h0;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_q         <= 1'b0;
         w_q          <= 1'b0;
         awaddr_q     <= 12'h000;
         wd_q         <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q  <= 1'b1;
            wd_q <= s_axi_wdata;
         end
         if (aw_q && w_q)
         begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // register writes; a start while busy is dropped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmd_q   <= 3'h0;
         addr_q  <= 18'h00000;
         wdata_q <= 16'h0000;
         mask_q  <= 16'hffff;
         be_q    <= 2'h3;
         start_q <= 1'b0;
      end
      else
      begin
         // refresh commands leave idle through the cbr state
         if (st_q == VDC_ST_RAS || st_q == VDC_ST_CBR)
            start_q <= 1'b0;
         if (aw_q && w_q && s_axi_wstrb != 4'h0)
         begin
            case (awaddr_q)
               `VDC_REG_CTRL:
               begin
                  if (!busy)
                  begin
                     cmd_q   <= wd_q[2:0];
                     be_q    <= wd_q[`VDC_CTRL_BE_HI:`VDC_CTRL_BE_LO];
                     start_q <= wd_q[`VDC_CTRL_START];
                  end
               end
               `VDC_REG_ADDR:  addr_q  <= wd_q[17:0];
               `VDC_REG_WDATA: wdata_q <= wd_q[15:0];
               `VDC_REG_MASK:  mask_q  <= wd_q[15:0];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            `VDC_REG_CTRL:  s_axi_rdata <= {26'h0, be_q, start_q, cmd_q};
            `VDC_REG_ADDR:  s_axi_rdata <= {14'h0, addr_q};
            `VDC_REG_WDATA: s_axi_rdata <= {16'h0, wdata_q};
            `VDC_REG_MASK:  s_axi_rdata <= {16'h0, mask_q};
            `VDC_REG_RDATA: s_axi_rdata <= {16'h0, rdata_q};
            `VDC_REG_STAT:
               s_axi_rdata <= {29'h0, oldmask_q,
                               st_q != VDC_ST_PWRUP && st_q != VDC_ST_INIT,
                               busy};
            default:        s_axi_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
   assign s_axi_rresp = (s_axi_rvalid && s_axi_araddr > `VDC_REG_STAT)
                        ? 2'h0 : 2'h0;

   // ----------------------------------------------------------------
   // strobe sequencer
   // ----------------------------------------------------------------
   // each state but power-up and idle holds its pins for tmr_q cycles; widths never cut short
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q    <= VDC_ST_PWRUP;
         pwr_q   <= 18'h00000;
         tmr_q   <= 16'h0000;
         icnt_q  <= 4'h0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         if (tmr_q != 16'h0000)
            tmr_q <= tmr_q - 16'h0001;
         case (st_q)
            VDC_ST_PWRUP:
            begin
               pwr_q <= pwr_q + 18'h00001;
               if (pwr_q == 18'(PWRUP - 1))
               begin
                  st_q  <= VDC_ST_INIT;
                  tmr_q <= C_RP;
               end
            end
            VDC_ST_INIT:
            begin
               // ras-only init; counter refresh only after init
               if (tmr_q == 16'h0000)
               begin
                  if (row_strobe_n && icnt_q == 4'(`VDC_INIT_CYCLES))
                     st_q <= VDC_ST_IDLE;
                  else
                  begin
                     tmr_q <= row_strobe_n ? C_RAS : C_RP;
                     if (row_strobe_n)
                        icnt_q <= icnt_q + 4'h1;
                  end
               end
            end
            VDC_ST_IDLE:
               if (start_q)
               begin
                  tmr_q <= (cmd_q == VDC_CMD_REFRESH ||
                            cmd_q == VDC_CMD_OPTRST) ? C_CSR : C_RAH;
                  st_q  <= (cmd_q == VDC_CMD_REFRESH ||
                            cmd_q == VDC_CMD_OPTRST) ? VDC_ST_CBR
                                                     : VDC_ST_RAS;
               end
            VDC_ST_CBR:
               if (tmr_q == 16'h0000)
               begin
                  st_q  <= VDC_ST_HOLD;
                  tmr_q <= C_RAS;
               end
            VDC_ST_RAS:
               if (tmr_q == 16'h0000)
               begin
                  st_q  <= VDC_ST_COL;
                  tmr_q <= 16'h0001;
               end
            VDC_ST_COL:
               if (tmr_q == 16'h0000)
               begin
                  st_q  <= VDC_ST_CAS;
                  tmr_q <= C_RAS > C_OEA ? C_RAS : C_OEA;
               end
            VDC_ST_CAS:
               if (tmr_q == 16'h0000)
               begin
                  if (cmd_q == VDC_CMD_READ)
                     rdata_q <= din;
                  st_q  <= VDC_ST_DATA;
                  tmr_q <= C_DH;
               end
            VDC_ST_DATA:
               if (tmr_q == 16'h0000)
               begin
                  st_q  <= VDC_ST_PRE;
                  tmr_q <= C_RP;
               end
            VDC_ST_HOLD:
               if (tmr_q == 16'h0000)
               begin
                  st_q  <= VDC_ST_PRE;
                  tmr_q <= C_RP;
               end
            VDC_ST_PRE:
               if (tmr_q == 16'h0000)
                  st_q <= VDC_ST_IDLE;
            default:
               st_q <= VDC_ST_IDLE;
         endcase
      end
   end

   // mask mode tracker mirrors the device
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         oldmask_q <= 1'b0;
      else if (st_q == VDC_ST_RAS && tmr_q == C_RAH
               && cmd_q == VDC_CMD_LOADMASK)
         oldmask_q <= 1'b1;
      else if (st_q == VDC_ST_CBR && cmd_q == VDC_CMD_OPTRST)
         oldmask_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         row_strobe_n              <= 1'b1;
         col_strobe_n              <= 1'b1;
         dram_addr                 <= 9'h000;
         lower_byte_write_enable_n <= 1'b1;
         upper_byte_write_enable_n <= 1'b1;
         transfer_output_enable_n  <= 1'b1;
         special_function_select   <= 1'b0;
         serial_shift_clock        <= 1'b0;
         data_mask_pins_o          <= 16'h0000;
         data_mask_pins_oe_n       <= 1'b1;
      end
      else
      begin
         serial_shift_clock <= 1'b0;
         case (st_q)
            VDC_ST_INIT:
            begin
               transfer_output_enable_n <= 1'b1;
               if (tmr_q == 16'h0000 && !(row_strobe_n &&
                   icnt_q == 4'(`VDC_INIT_CYCLES)))
                  row_strobe_n <= !row_strobe_n;
               serial_shift_clock <= !row_strobe_n;
            end
            VDC_ST_IDLE:
            begin
               // row address settles a cycle ahead of the row strobe fall
               dram_addr <= addr_q[17:9];
               if (start_q)
               begin
                  if (cmd_q == VDC_CMD_REFRESH || cmd_q == VDC_CMD_OPTRST)
                  begin
                     col_strobe_n            <= 1'b0;
                     special_function_select <= cmd_q == VDC_CMD_REFRESH;
                  end
                  else
                  begin
                     row_strobe_n <= 1'b0;
                     // masked write: enables low, select low
                     lower_byte_write_enable_n <= cmd_q != VDC_CMD_MWRITE;
                     upper_byte_write_enable_n <= cmd_q != VDC_CMD_MWRITE;
                     special_function_select   <= cmd_q == VDC_CMD_LOADMASK;
                     data_mask_pins_o          <= mask_q;
                     data_mask_pins_oe_n <= cmd_q != VDC_CMD_MWRITE
                                            || oldmask_q;
                  end
               end
            end
            VDC_ST_CBR:
               if (tmr_q == 16'h0000)
                  row_strobe_n <= 1'b0;
            VDC_ST_RAS:
               if (tmr_q == 16'h0000)
               begin
                  dram_addr               <= addr_q[8:0];
                  special_function_select <= 1'b0;
                  data_mask_pins_oe_n     <= 1'b1;
                  // early write: enables down before column fall
                  lower_byte_write_enable_n <= !(is_wr || cmd_q ==
                                    VDC_CMD_LOADMASK) || !be_q[0];
                  upper_byte_write_enable_n <= !(is_wr || cmd_q ==
                                    VDC_CMD_LOADMASK) || !be_q[1];
                  data_mask_pins_o <= cmd_q == VDC_CMD_LOADMASK ? mask_q
                                                                : wdata_q;
               end
            VDC_ST_COL:
            begin
               col_strobe_n <= 1'b0;
               transfer_output_enable_n <= cmd_q != VDC_CMD_READ;
               data_mask_pins_oe_n <= cmd_q == VDC_CMD_READ;
            end
            VDC_ST_DATA:
               if (tmr_q == 16'h0000)
               begin
                  row_strobe_n              <= 1'b1;
                  col_strobe_n              <= 1'b1;
                  lower_byte_write_enable_n <= 1'b1;
                  upper_byte_write_enable_n <= 1'b1;
                  transfer_output_enable_n  <= 1'b1;
                  data_mask_pins_oe_n       <= 1'b1;
               end
            VDC_ST_HOLD:
               if (tmr_q == 16'h0000)
               begin
                  row_strobe_n            <= 1'b1;
                  col_strobe_n            <= 1'b1;
                  special_function_select <= 1'b0;
               end
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== test/vdc_ctrl_sva.sv
// concurrent checks on the device-side pins of the controller
`default_nettype none
module vdc_chk (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       row_strobe_n,
   input wire logic       col_strobe_n,
   input wire logic [8:0] dram_addr,
   input wire logic       lower_byte_write_enable_n,
   input wire logic       upper_byte_write_enable_n,
   input wire logic       transfer_output_enable_n,
   input wire logic       special_function_select,
   input wire logic       serial_shift_clock,
   input wire logic       data_mask_pins_oe_n
   );
   timeunit 1ns;
   timeprecision 1ps;
   logic       rv_q;
   logic [7:0] run_q;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // samples spent at the current row strobe level, saturating on idle
   always_ff @(posedge aclk)
   begin
      rv_q <= row_strobe_n;
      if (!aresetn || row_strobe_n != rv_q)
         run_q <= 8'h01;
      else if (run_q != 8'hff)
         run_q <= run_q + 8'h01;
   end
   a_init_oe_high: assert property (serial_shift_clock |-> transfer_output_enable_n)
      else $error("shift clock pulsed with output enable low");
   a_rp_min: assert property ($fell(row_strobe_n) |-> run_q >= 8'd15)
      else $error("row precharge too short");
   a_ras_min: assert property ($rose(row_strobe_n) |-> run_q >= 8'd20)
      else $error("row strobe pulse too short");
   a_cas_min: assert property ($fell(col_strobe_n) |-> !col_strobe_n[*5])
      else $error("column strobe pulse too short");
   a_row_addr_hold: assert property ($fell(row_strobe_n) |-> $stable(dram_addr)[*3])
      else $error("row address moved around row strobe fall");
   a_col_addr_hold: assert property ($fell(col_strobe_n) && !row_strobe_n
      |-> $stable(dram_addr)[*3])
      else $error("column address moved around column strobe fall");
   a_cbr_setup: assert property ($fell(row_strobe_n) && !col_strobe_n
      |-> !$past(col_strobe_n, 2))
      else $error("column strobe setup before row strobe too short");
   a_read_we_high: assert property (!transfer_output_enable_n
      |-> lower_byte_write_enable_n && upper_byte_write_enable_n)
      else $error("write enable low while reading");
   a_no_bus_fight: assert property (!transfer_output_enable_n |-> data_mask_pins_oe_n)
      else $error("controller drives data while device output enabled");
   cover property ($fell(col_strobe_n) && !row_strobe_n && !transfer_output_enable_n);
   cover property ($fell(row_strobe_n) && !col_strobe_n);
   cover property ($fell(row_strobe_n) && !data_mask_pins_oe_n);
endmodule

bind vdc_ctrl vdc_chk u_chk (.aclk, .aresetn, .row_strobe_n, .col_strobe_n,
   .dram_addr, .lower_byte_write_enable_n, .upper_byte_write_enable_n,
   .transfer_output_enable_n, .special_function_select,
   .serial_shift_clock, .data_mask_pins_oe_n);
`default_nettype wire

// ===== test/vdc_dev_model.sv
// behavioural model of the video dram random-access port
`default_nettype none
module vdc_dev_model (
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic [8:0]  addr,
   input  wire logic        wel_n,
   input  wire logic        weu_n,
   input  wire logic        toe_n,
   input  wire logic        sfs,
   input  wire logic [15:0] din,
   output logic      [15:0] dq
   );
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [256];
   logic [15:0] wm_q;
   logic [15:0] msk_q;
   logic [15:0] rd_q = 16'h0000;
   logic [8:0]  row_q;
   logic        old_q = 1'b0;
   logic        lmr_q = 1'b0;
   logic        rdo_q = 1'b0;
   logic        we_any;
   assign we_any = !wel_n || !weu_n;
   function automatic logic [15:0] merge(input logic [15:0] o, n, m);
      merge = o;
      if (!wel_n)
         merge[7:0] = (o[7:0] & ~m[7:0]) | (n[7:0] & m[7:0]);
      if (!weu_n)
         merge[15:8] = (o[15:8] & ~m[15:8]) | (n[15:8] & m[15:8]);
   endfunction
   // pins driven on the strobe's own edge are taken once settled
   always @(negedge ras_n)
   begin
      #1;
      row_q = addr;
      lmr_q = sfs && !we_any && cas_n;
      wm_q = 16'hffff;
      if (!cas_n && !sfs)
         old_q = 1'b0;
      else if (cas_n && we_any && !sfs)
         wm_q = old_q ? msk_q : din;
   end
   // only four row and four column bits index the small array
   always @(negedge cas_n)
   begin
      #1;
      if (!ras_n && lmr_q && !sfs)
      begin
         msk_q = merge(msk_q, din, 16'hffff);
         old_q = 1'b1;
      end
      else if (!ras_n && we_any)
         mem[{row_q[3:0], addr[3:0]}] =
            merge(mem[{row_q[3:0], addr[3:0]}], din, wm_q);
      else if (!ras_n && !lmr_q)
      begin
         rd_q = mem[{row_q[3:0], addr[3:0]}];
         rdo_q = 1'b1;
      end
   end
   always @(posedge ras_n or posedge cas_n)
      if (ras_n && cas_n)
         rdo_q = 1'b0;
   // released pins show the inverse so a stale value cannot pass
   assign dq = (rdo_q && !toe_n && !we_any) ? rd_q : ~rd_q;
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the video dram controller
`include "vdc_consts.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, serial_shift_clock;
   logic [31:0] s_axi_rdata, rv;
   logic        row_strobe_n, col_strobe_n, data_mask_pins_oe_n;
   logic        lower_byte_write_enable_n, upper_byte_write_enable_n;
   logic        transfer_output_enable_n, special_function_select;
   logic [8:0]  dram_addr;
   logic [15:0] data_mask_pins_o, mdl_q;
   wire logic [15:0] data_mask_pins_i =
      data_mask_pins_oe_n ? mdl_q : data_mask_pins_o;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          first_fall = 0;
   int          pulses = 0;
   vdc_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp(), .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp(), .s_axi_rvalid, .s_axi_rready, .row_strobe_n,
      .col_strobe_n, .dram_addr, .lower_byte_write_enable_n,
      .upper_byte_write_enable_n, .transfer_output_enable_n,
      .special_function_select, .serial_shift_clock, .data_mask_pins_i,
      .data_mask_pins_o, .data_mask_pins_oe_n);
   vdc_dev_model u_dev (.ras_n(row_strobe_n), .cas_n(col_strobe_n),
      .addr(dram_addr), .wel_n(lower_byte_write_enable_n),
      .weu_n(upper_byte_write_enable_n), .toe_n(transfer_output_enable_n),
      .sfs(special_function_select), .din(data_mask_pins_i), .dq(mdl_q));
   always #2 aclk = ~aclk;
   always @(posedge serial_shift_clock)
      pulses++;
   always @(negedge row_strobe_n)
      if (first_fall == 0)
         first_fall = cyc;
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // a hang is cut off well beyond the power-up pause plus the tests
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         miscompares++;
         end_of_test;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // handshakes are sampled at the rising edge, before the design updates
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic tk;
      tk = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!tk)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         tk = s_axi_bvalid;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      logic tk;
      tk = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!tk)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         tk = s_axi_rvalid;
         d = s_axi_rdata;
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic op(input logic [2:0] c, input logic [1:0] be,
                     input logic [17:0] a, input logic [15:0] d, m);
      logic [31:0] s;
      wr(`VDC_REG_ADDR, {14'h0, a});
      wr(`VDC_REG_WDATA, {16'h0, d});
      wr(`VDC_REG_MASK, {16'h0, m});
      wr(`VDC_REG_CTRL, {26'h0, be, 1'b1, c});
      s = 32'h1;
      while (s[0])
         rd(`VDC_REG_STAT, s);
   endtask
   task automatic peek(input logic [17:0] a, input logic [15:0] e);
      logic [31:0] v;
      op(3'h0, 2'h3, a, 16'h0, 16'h0);
      rd(`VDC_REG_RDATA, v);
      chk("read data", {16'h0, e}, v);
   endtask
   initial
   begin
      rv = 32'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      while (!rv[1])
         rd(`VDC_REG_STAT, rv);
      chk("status", 32'h2, rv);
      chk("pause", 32'h1, {31'h0, first_fall >= 50000});
      chk("shift pulses", 32'd8, pulses);
      op(3'h1, 2'h3, 18'h00202, 16'h1234, 16'h0);
      peek(18'h00202, 16'h1234);
      op(3'h1, 2'h1, 18'h00202, 16'habcd, 16'h0);
      peek(18'h00202, 16'h12cd);
      op(3'h2, 2'h3, 18'h00202, 16'hffff, 16'h00ff);
      peek(18'h00202, 16'h12ff);
      op(3'h3, 2'h3, 18'h00202, 16'h0, 16'hf000);
      rd(`VDC_REG_STAT, rv);
      chk("status", 32'h6, rv);
      op(3'h2, 2'h3, 18'h00202, 16'h0, 16'h00ff);
      peek(18'h00202, 16'h02ff);
      op(3'h4, 2'h3, 18'h0, 16'h0, 16'h0);
      rd(`VDC_REG_STAT, rv);
      chk("status", 32'h6, rv);
      op(3'h5, 2'h3, 18'h0, 16'h0, 16'h0);
      rd(`VDC_REG_STAT, rv);
      chk("status", 32'h2, rv);
      op(3'h2, 2'h3, 18'h00202, 16'h0, 16'h0001);
      peek(18'h00202, 16'h02fe);
      op(3'h1, 2'h3, 18'h00402, 16'h5a5a, 16'h0);
      peek(18'h00402, 16'h5a5a);
      peek(18'h00202, 16'h02fe);
      rd(12'h0f0, rv);
      chk("unmapped", 32'h0, rv);
      end_of_test;
   end
endmodule
`default_nettype wire
